/* design/dcc_pkg.sv */
/*
 * Package for the dual counter common control block: register offsets,
 * field positions, reset values, carrier structs and mode enumeration.
 * Assumes a 32-bit APB master and one system clock.
 */
`default_nettype none
package dcc_pkg;
    // =========================================================
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_BYTE_CTRL   = 4'h0;
    localparam logic [3:0] IDX_MODE_CTRL   = 4'h1;
    localparam logic [3:0] IDX_WORD_CTRL   = 4'h2;
    localparam logic [3:0] IDX_SHARED_CTRL = 4'h3;
    localparam logic [3:0] IDX_IRQ_STAT    = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK    = 4'h5;
    localparam logic [3:0] IDX_BYTE_INIT   = 4'h6;
    localparam logic [3:0] IDX_WORD_INIT   = 4'h7;
    // =========================================================
    // Shared control fields
    localparam int SH_WORD_RUN = 7;
    localparam int SH_BYTE_RUN = 6;
    localparam int SH_SYNC     = 5;
    localparam logic [4:0] SH_RSVD_RD = 5'h1F;
    // Per-counter control fields
    localparam int CT_RUN    = 7;
    localparam int CT_SINGLE = 6;
    localparam int CT_TOUT   = 5;
    // Mode control fields
    localparam int MD_DEMOD  = 7;
    localparam int MD_PP_LO  = 2;
    localparam int MD_PP_HI  = 3;
    // Interrupt status bits
    localparam int IRQ_BYTE_TC = 0;
    localparam int IRQ_WORD_TC = 1;
    localparam int IRQ_SYNC    = 2;
    // =========================================================
    // Reset values
    localparam logic [7:0]  RST_CTRL = 8'h00;
    localparam logic [15:0] RST_INIT = 16'h0002;
    typedef enum logic [1:0] {DCC_TRANSMIT, DCC_DEMOD} dcc_mode_t;
    typedef struct packed {
        logic        run;
        logic        single;
        logic        tout;
    } dcc_cnt_ctrl_t;
    typedef struct packed {
        logic        start;
        logic        stop;
        logic        tc_pulse;
        logic        busy;
    } dcc_cnt_stat_t;
endpackage
`default_nettype wire

/* design/dcc_counter.sv */
/*
 * Down counter with reload: counts while enabled, pulses at terminal
 * count, reloads its initial value on start and on modulo-N wrap.
 * Assumes enable and load come from logic on the same clock.
 */
`default_nettype none
module dcc_counter
(
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    // Control
    input  wire logic                  run_i,
    input  wire logic                  load_i,
    input  wire logic [15:0]           init_i,
    // Status
    output logic                       tc_o,
    output logic [15:0]                count_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // =========================================================
    // Count
    always_comb
    begin
        cnt_d = cnt_q;
        if (load_i)
        begin
            cnt_d = init_i;
        end
        else if (run_i)
        begin
            cnt_d = (cnt_q == 16'h0001) ? init_i : cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 16'h0000;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign tc_o    = run_i && !load_i && (cnt_q == 16'h0001);
    assign count_o = cnt_q;
endmodule
`default_nettype wire

/* design/dcc_top.sv */
/*
 * Common control for an 8-bit and a 16-bit counter behind APB: shared
 * run bits, sync option, single-pass, ping-pong and sticky interrupts.
 * Assumes an APB master on mclk_i and a stop-recovery pulse from the
 * system that clears the counter control (run, single, timeout), mode, wait and output registers and keeps sync, status flags, mask and init values.
 */
// How it works
// - Shared low five bits ignore writes, read ones
// - Sync bit resets zero, survives stop recovery
// - Byte run bit: read state, write start/stop
// - Word run bit: read state, write start/stop
// - Sync delays byte start to demodulated edge in demod mode
// - Mode register bits decode per active mode
// - Single-pass halts, modulo-N reloads at terminal
// - Ping-pong hands run between the counters
// - Each terminal count sets its timeout flag
`default_nettype none
module dcc_top
(
    // Clock and resets
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  stop_recover_i,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Demodulated signal and outputs
    input  wire logic                  demod_in_i,
    output logic                       byte_out_o,
    output logic                       word_out_o,
    output logic                       irq_o
);
    // =========================================================
    // State
    dcc_pkg::dcc_cnt_ctrl_t byte_q, byte_d, word_q, word_d;
    logic [7:0]  mode_q, mode_d;
    logic        sync_q, sync_d;
    logic        wait_q, wait_d;
    logic [2:0]  stat_q, stat_d, mask_q, mask_d;
    logic [7:0]  binit_q, binit_d;
    logic [15:0] winit_q, winit_d;
    logic        bout_q, bout_d, wout_q, wout_d;
    logic        dm_s1_q, dm_s2_q, dm_s3_q;
    logic [31:0] rdata_q, rdata_d;
    logic        bload, wload, btc, wtc, wr, rd, hit, sync_edge;
    logic [3:0]  idx;
    logic [15:0] bcnt;
    dcc_pkg::dcc_mode_t mode;

    function automatic logic [7:0] ctrl_rd(dcc_pkg::dcc_cnt_ctrl_t c,
                                           logic [7:0] base);
        logic [7:0] v;
        v = base;
        v[dcc_pkg::CT_RUN]    = c.run;
        v[dcc_pkg::CT_SINGLE] = c.single;
        v[dcc_pkg::CT_TOUT]   = c.tout;
        return v;
    endfunction

    // =========================================================
    // Bus decode
    assign idx     = paddr[5:2];
    assign hit     = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0)
                     && (idx <= dcc_pkg::IDX_WORD_INIT);
    assign wr      = psel && penable && pwrite && hit;
    assign rd      = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = rdata_q;
    assign mode = mode_q[dcc_pkg::MD_DEMOD] ? dcc_pkg::DCC_DEMOD
                                            : dcc_pkg::DCC_TRANSMIT;
    assign sync_edge = dm_s2_q && !dm_s3_q;

    // =========================================================
    // Counters
    dcc_counter u_byte
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .run_i   (byte_q.run && !wait_q),
        .load_i  (bload),
        .init_i  ({8'h00, binit_q}),
        .tc_o    (btc),
        .count_o (bcnt)
    );
    dcc_counter u_word
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .run_i   (word_q.run),
        .load_i  (wload),
        .init_i  (winit_q),
        .tc_o    (wtc),
        .count_o ()
    );

    // =========================================================
    // Control next state
    always_comb
    begin
        logic pp;
        pp      = mode_q[dcc_pkg::MD_PP_LO] && mode_q[dcc_pkg::MD_PP_HI]
                  && (mode == dcc_pkg::DCC_TRANSMIT);
        byte_d  = byte_q;
        word_d  = word_q;
        mode_d  = mode_q;
        sync_d  = sync_q;
        wait_d  = wait_q;
        stat_d  = stat_q;
        mask_d  = mask_q;
        binit_d = binit_q;
        winit_d = winit_q;
        bout_d  = bout_q;
        wout_d  = wout_q;
        // Terminal count events
        if (btc)
        begin
            bout_d = !bout_q;
            if (byte_q.single || pp)
            begin
                byte_d.run = 1'b0;
                if (pp)
                begin
                    word_d.run = 1'b1;
                end
            end
        end
        if (wtc)
        begin
            wout_d = !wout_q;
            if (word_q.single || pp)
            begin
                word_d.run = 1'b0;
                if (pp)
                begin
                    byte_d.run = 1'b1;
                end
            end
        end
        if (wait_q && sync_edge)
        begin
            wait_d = 1'b0;
        end
        // Register writes
        if (wr)
        begin
            case (idx)
                dcc_pkg::IDX_BYTE_CTRL:
                begin
                    byte_d.run    = pwdata[dcc_pkg::CT_RUN];
                    byte_d.single = pwdata[dcc_pkg::CT_SINGLE];
                    if (pwdata[dcc_pkg::CT_TOUT])
                    begin
                        byte_d.tout = 1'b0;
                    end
                end
                dcc_pkg::IDX_MODE_CTRL:   mode_d = pwdata[7:0];
                dcc_pkg::IDX_WORD_CTRL:
                begin
                    word_d.run    = pwdata[dcc_pkg::CT_RUN];
                    word_d.single = pwdata[dcc_pkg::CT_SINGLE];
                    if (pwdata[dcc_pkg::CT_TOUT])
                    begin
                        word_d.tout = 1'b0;
                    end
                end
                dcc_pkg::IDX_SHARED_CTRL:
                begin
                    word_d.run = pwdata[dcc_pkg::SH_WORD_RUN];
                    byte_d.run = pwdata[dcc_pkg::SH_BYTE_RUN];
                    sync_d     = pwdata[dcc_pkg::SH_SYNC];
                end
                dcc_pkg::IDX_IRQ_STAT:   stat_d = stat_q & ~pwdata[2:0];
                dcc_pkg::IDX_IRQ_MASK:   mask_d = pwdata[2:0];
                dcc_pkg::IDX_BYTE_INIT:  binit_d = pwdata[7:0];
                dcc_pkg::IDX_WORD_INIT:  winit_d = pwdata[15:0];
                default:                 mask_d = mask_q;
            endcase
        end
        // Byte start arms the sync wait
        if (byte_d.run && !byte_q.run)
        begin
            wait_d = sync_q && (mode == dcc_pkg::DCC_DEMOD);
        end
        // Sticky flags: set wins over clear
        if (btc)
        begin
            byte_d.tout = 1'b1;
            stat_d[dcc_pkg::IRQ_BYTE_TC] = 1'b1;
        end
        if (wtc)
        begin
            word_d.tout = 1'b1;
            stat_d[dcc_pkg::IRQ_WORD_TC] = 1'b1;
        end
        if (wait_q && sync_edge)
        begin
            stat_d[dcc_pkg::IRQ_SYNC] = 1'b1;
        end
        if (!byte_d.run)
        begin
            bout_d = 1'b0;
            wait_d = 1'b0;
        end
        if (!word_d.run)
        begin
            wout_d = 1'b0;
        end
    end

    assign bload = byte_d.run && !byte_q.run;
    assign wload = word_d.run && !word_q.run;

    // =========================================================
    // Read data
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd)
        begin
            case (idx)
                dcc_pkg::IDX_BYTE_CTRL:
                    rdata_d = {24'h0, ctrl_rd(byte_q, 8'h00)};
                dcc_pkg::IDX_MODE_CTRL:   rdata_d = {24'h0, mode_q};
                dcc_pkg::IDX_WORD_CTRL:
                    rdata_d = {24'h0, ctrl_rd(word_q, 8'h00)};
                dcc_pkg::IDX_SHARED_CTRL:
                    rdata_d = {24'h0, word_q.run, byte_q.run, sync_q,
                               dcc_pkg::SH_RSVD_RD};
                dcc_pkg::IDX_IRQ_STAT:  rdata_d = {29'h0, stat_q};
                dcc_pkg::IDX_IRQ_MASK:  rdata_d = {29'h0, mask_q};
                dcc_pkg::IDX_BYTE_INIT: rdata_d = {24'h0, binit_q};
                dcc_pkg::IDX_WORD_INIT: rdata_d = {16'h0, winit_q};
                default:                rdata_d = 32'h0;
            endcase
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            byte_q  <= '0;
            word_q  <= '0;
            mode_q  <= dcc_pkg::RST_CTRL;
            wait_q  <= 1'b0;
            stat_q  <= 3'h0;
            mask_q  <= 3'h0;
            binit_q <= dcc_pkg::RST_INIT[7:0];
            winit_q <= dcc_pkg::RST_INIT;
            bout_q  <= 1'b0;
            wout_q  <= 1'b0;
            rdata_q <= 32'h0;
            dm_s1_q <= 1'b0;
            dm_s2_q <= 1'b0;
            dm_s3_q <= 1'b0;
        end
        else
        begin
            dm_s1_q <= demod_in_i;
            dm_s2_q <= dm_s1_q;
            dm_s3_q <= dm_s2_q;
            rdata_q <= rdata_d;
            if (stop_recover_i)
            begin
                byte_q <= '0;
                word_q <= '0;
                mode_q <= dcc_pkg::RST_CTRL;
                wait_q <= 1'b0;
                bout_q <= 1'b0;
                wout_q <= 1'b0;
            end
            else
            begin
                byte_q <= byte_d;
                word_q <= word_d;
                mode_q <= mode_d;
                wait_q <= wait_d;
                bout_q <= bout_d;
                wout_q <= wout_d;
            end
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            binit_q <= binit_d;
            winit_q <= winit_d;
        end
    end

    assign byte_out_o = bout_q;
    assign word_out_o = wout_q;
    assign irq_o      = |(stat_q & mask_q);

    // =========================================================
    // Checks
    a_rsvd_reads_ones: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd && idx == dcc_pkg::IDX_SHARED_CTRL
        |=> rdata_q[4:0] == dcc_pkg::SH_RSVD_RD)
        else $error("reserved bits not ones");
    a_sync_keeps: assert property (@(posedge mclk_i) disable iff (rst_i)
        stop_recover_i && !wr |=> sync_q == $past(sync_q))
        else $error("sync lost on recovery");
    a_byte_run_wr: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && idx == dcc_pkg::IDX_SHARED_CTRL && !stop_recover_i
        |=> byte_q.run == $past(pwdata[dcc_pkg::SH_BYTE_RUN]))
        else $error("byte run write lost");
    a_word_run_wr: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && idx == dcc_pkg::IDX_SHARED_CTRL && !stop_recover_i
        |=> word_q.run == $past(pwdata[dcc_pkg::SH_WORD_RUN]))
        else $error("word run write lost");
    a_sync_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
        wait_q && !sync_edge && !wr && !stop_recover_i |=> bcnt == $past(bcnt))
        else $error("byte ran before sync");
    a_single_halts: assert property (@(posedge mclk_i) disable iff (rst_i)
        btc && byte_q.single && !wr && !stop_recover_i |=> !byte_q.run)
        else $error("single pass did not halt");
    a_pingpong_hand: assert property (@(posedge mclk_i) disable iff (rst_i)
        wtc && mode_q[3:2] == 2'b11 && !mode_q[7] && !wr && !stop_recover_i
        |=> byte_q.run && !word_q.run)
        else $error("ping-pong handover missing");
    a_tc_sets_tout: assert property (@(posedge mclk_i) disable iff (rst_i)
        wtc && !stop_recover_i |=> word_q.tout)
        else $error("timeout flag not set");
    a_same_storage: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr && idx == dcc_pkg::IDX_BYTE_CTRL && !stop_recover_i
        |=> byte_q.run == $past(pwdata[dcc_pkg::CT_RUN]))
        else $error("run storage not shared");
endmodule
`default_nettype wire

/* test/dcc_top_tb_top.sv */
/*
 * Self-checking bench for dcc_top: shared register, run bits, sync,
 * single-pass, ping-pong, interrupts and stop recovery over APB.
 * Assumes dcc_pkg and the design files are compiled before it.
 */
`default_nettype none
module dcc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals
    logic        mclk_i;
    logic        rst_i;
    logic        stop_recover_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        demod_in_i;
    logic        byte_out_o;
    logic        word_out_o;
    logic        irq_o;
    logic [31:0] rdat;
    logic        rerr;
    logic [7:0]  w;
    int          err_count;
    int          n_tests;
    int          cyc;
    int          seed;
    int          k;
    // ==========================================================
    // Design
    dcc_top DUT
    (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .stop_recover_i (stop_recover_i),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .demod_in_i     (demod_in_i),
        .byte_out_o     (byte_out_o),
        .word_out_o     (word_out_o),
        .irq_o          (irq_o)
    );
    // ==========================================================
    // Clock and timeout
    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] ad(input logic [3:0] idx);
        return {26'h0, idx, 2'b00};
    endfunction
    function automatic logic [31:0] exp_sh(input logic [7:0] v);
        return {24'h0, v[7:5], dcc_pkg::SH_RSVD_RD};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1)
        begin
            @(posedge mclk_i);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        apb(1'b1, ad(idx), d);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] e);
        apb(1'b0, ad(idx), 32'h0);
        chk(rdat, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        seed = 32'h4E138B54;
        rst_i = 1'b1;
        stop_recover_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        demod_in_i = 1'b0;
        idle(12);
        rst_i <= 1'b0;
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h1F);
        apb(1'b0, 32'h20, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        // Run bit written per counter, seen in shared register
        wr(dcc_pkg::IDX_BYTE_INIT, 32'h5);
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'h80);
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h5F);
        wr(dcc_pkg::IDX_SHARED_CTRL, 32'h80);
        rd(dcc_pkg::IDX_WORD_CTRL, 32'h80);
        rd(dcc_pkg::IDX_BYTE_CTRL, 32'h20);
        wr(dcc_pkg::IDX_SHARED_CTRL, 32'h00);
        wr(dcc_pkg::IDX_WORD_CTRL, 32'h20);
        wr(dcc_pkg::IDX_IRQ_STAT, 32'h7);
        // Single pass, then interrupt mask and clear
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'hC0);
        idle(20);
        rd(dcc_pkg::IDX_BYTE_CTRL, 32'h60);
        rd(dcc_pkg::IDX_IRQ_STAT, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(dcc_pkg::IDX_IRQ_MASK, 32'h1);
        idle(1);
        chk({31'h0, irq_o}, 32'h1);
        wr(dcc_pkg::IDX_IRQ_STAT, 32'h1);
        idle(1);
        chk({31'h0, irq_o}, 32'h0);
        // Modulo-N keeps running
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'hA0);
        idle(20);
        rd(dcc_pkg::IDX_BYTE_CTRL, 32'hA0);
        // Random shared register writes
        for (k = 0; k < 10; k++)
        begin
            w = (k == 0) ? 8'h1F : 8'($random(seed));
            demod_in_i <= w[0];
            wr(dcc_pkg::IDX_SHARED_CTRL, {24'h0, w});
            rd(dcc_pkg::IDX_SHARED_CTRL, exp_sh(w));
        end
        // Stop recovery keeps sync, reset clears it
        wr(dcc_pkg::IDX_SHARED_CTRL, 32'hE0);
        @(posedge mclk_i);
        stop_recover_i <= 1'b1;
        @(posedge mclk_i);
        stop_recover_i <= 1'b0;
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h3F);
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h1F);
        // Ping-pong between the counters
        wr(dcc_pkg::IDX_BYTE_INIT, 32'd40);
        wr(dcc_pkg::IDX_WORD_INIT, 32'd60);
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'h40);
        wr(dcc_pkg::IDX_WORD_CTRL, 32'h40);
        wr(dcc_pkg::IDX_MODE_CTRL, 32'h0C);
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'hC0);
        idle(8);
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h5F);
        idle(40);
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h9F);
        rd(dcc_pkg::IDX_BYTE_CTRL, 32'h60);
        idle(55);
        rd(dcc_pkg::IDX_SHARED_CTRL, 32'h5F);
        rd(dcc_pkg::IDX_WORD_CTRL, 32'h60);
        wr(dcc_pkg::IDX_SHARED_CTRL, 32'h00);
        // Sync in demodulation mode waits for the demodulated edge
        demod_in_i <= 1'b0;
        wr(dcc_pkg::IDX_MODE_CTRL, 32'h80);
        wr(dcc_pkg::IDX_SHARED_CTRL, 32'h20);
        wr(dcc_pkg::IDX_BYTE_INIT, 32'h4);
        wr(dcc_pkg::IDX_BYTE_CTRL, 32'h80);
        w = 8'h0;
        repeat (30)
        begin
            @(negedge mclk_i);
            w[0] = w[0] | byte_out_o;
        end
        chk({31'h0, w[0]}, 32'h0);
        @(posedge mclk_i);
        demod_in_i <= 1'b1;
        repeat (20)
        begin
            @(negedge mclk_i);
            w[0] = w[0] | byte_out_o;
        end
        chk({31'h0, w[0]}, 32'h1);
        rd(dcc_pkg::IDX_IRQ_STAT, 32'h7);
        // Word counter output toggles in modulo-N
        wr(dcc_pkg::IDX_WORD_CTRL, 32'h80);
        repeat (70)
        begin
            @(negedge mclk_i);
            w[1] = w[1] | word_out_o;
        end
        chk({31'h0, w[1]}, 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire
